// >>> hdl/host_command_port.sv
`timescale 1ns/1ps
// How it works
// [RULE1] one jumpered port, writes only, reads ignored
// [RULE2] two low bits pick clear, start, reset
// [RULE3] clear drops interrupt and leaves reset
// [RULE4] host initializes drives before any access
// [RULE5] first start fetches tables, clears busy silently
// [RULE6] later starts fetch parameter block and run
// [RULE7] reset command resets at once, aborts, silent
// [RULE8] interrupt drives one of eight jumpered lines
// [RULE9] interrupt holds until clear or bus reset
// [RULE10] completion, seek and media change interrupt
// [RULE11] only completion interrupt can be suppressed
// [RULE12] modifier bit zero set suppresses completion interrupt
// [RULE13] segmented address is segment times 16 plus offset
// [RULE14] linear mode: first word low, second high
// [RULE15] wake-up block at jumper value times 16
// [RULE16] wake-up read only on first start
// [RULE17] extension byte 01H none, 07H all
// [RULE18] wake-up: extension, reserved, four address bytes
// [RULE19] busy byte FFH busy, 00H idle
// [RULE20] post status only when semaphore is zero
// [RULE21] low bits 03H write is ignored
module host_command_port #(
  parameter int PORT_W = 16
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic bus_init_in,
  // host i/o port
  input wire logic [PORT_W-1:0] io_addr_in,
  input wire logic io_write_in,
  input wire logic io_read_in,
  input wire logic [7:0] io_data_in,
  input wire logic wide_port_in,
  // board jumpers
  input wire logic [15:0] port_jumper_in,
  input wire logic [2:0] interrupt_line_jumper_in,
  // memory fetch of the wake-up block, one byte per request
  output logic mem_req_out,
  output logic [23:0] mem_addr_out,
  input wire logic mem_ack_in,
  input wire logic [7:0] mem_data_in,
  // engine events and parameter block fields
  input wire host_port_pkg::irq_events_t events_in,
  input wire logic [15:0] modifier_in,
  input wire logic semaphore_zero_in,
  input wire logic exec_done_in,
  input wire logic [15:0] seg_in,
  input wire logic [15:0] off_in,
  // outputs to the engine and the bus
  output logic busy_write_out,
  output logic [7:0] busy_value_out,
  output logic exec_start_out,
  output logic abort_out,
  output logic status_post_out,
  output logic in_reset_out,
  output logic linear_mode_out,
  output logic [7:0] ext_sel_out,
  output logic [23:0] chain_addr_out,
  output logic [23:0] xlate_addr_out,
  output logic [host_port_pkg::IRQ_LINES-1:0] irq_out
);
  // state registers
  host_port_pkg::state_t st_r, st_nxt;
  logic [2:0] idx_r, idx_nxt; // wake-up byte index
  logic [7:0] ext_r, ext_nxt; // extension selector
  logic [31:0] ccb_r, ccb_nxt; // saved chain words
  logic linked_r, linked_nxt; // wake-up already taken
  logic irq_r, irq_nxt; // sticky host interrupt
  logic [23:0] maddr_r, maddr_nxt;
  logic mreq_r, mreq_nxt;
  logic bw_r, bw_nxt; // busy byte write strobe
  logic [7:0] bv_r, bv_nxt;
  logic xs_r, xs_nxt;
  logic post_r, post_nxt;
  logic [23:0] xl_r, xl_nxt;

  // port decode: narrow ports compare only the low byte
  logic hit, wr_clear, wr_start, wr_reset;
  logic [1:0] cmd;
  assign cmd = io_data_in[1:0]; // RULE2
  always_comb begin
    if (wide_port_in) begin
      hit = (io_addr_in == PORT_W'(port_jumper_in)); // RULE1
    end else begin
      hit = (io_addr_in[7:0] == port_jumper_in[7:0]); // RULE1
    end
  end
  // reads never decode; 03H matches no command, so it falls through
  // every branch of the engine and leaves all state alone
  logic wr_hit;
  assign wr_hit = hit && io_write_in; // RULE1 RULE21
  assign wr_clear = wr_hit && cmd == host_port_pkg::CMD_CLEAR;
  assign wr_start = wr_hit && cmd == host_port_pkg::CMD_START;
  assign wr_reset = wr_hit && cmd == host_port_pkg::CMD_RESET;

  // wake-up block base; shift of the jumper value makes 20 bits
  logic [23:0] wake_base;
  assign wake_base = {4'h0, port_jumper_in, 4'h0}; // RULE15

  // segmented or linear translation of the chain words
  function automatic logic [23:0] xlate(input logic lin,
      input logic [15:0] w0, input logic [15:0] w1);
    logic [19:0] seg;
    seg = {w1, 4'h0} + {4'h0, w0}; // RULE13
    if (lin) begin
      xlate = {w1[7:0], w0}; // RULE14
    end else begin
      xlate = {4'h0, seg};
    end
  endfunction : xlate

  logic lin;
  assign lin = (ext_r == host_port_pkg::EXT_ALL); // RULE17

  // next-state logic of the engine
  always_comb begin
    st_nxt = st_r;
    idx_nxt = idx_r;
    ext_nxt = ext_r;
    ccb_nxt = ccb_r;
    linked_nxt = linked_r;
    irq_nxt = irq_r;
    maddr_nxt = maddr_r;
    mreq_nxt = 1'b0;
    bw_nxt = 1'b0;
    bv_nxt = bv_r;
    xs_nxt = 1'b0;
    post_nxt = 1'b0;
    xl_nxt = xlate(lin, off_in, seg_in);
    // events set the sticky interrupt; completion may be masked
    if (events_in.seek_done || events_in.media_change) begin
      irq_nxt = 1'b1; // RULE10 RULE11
    end
    if (events_in.cmd_done && !modifier_in[host_port_pkg::MOD_NO_INT_BIT]
        && st_r != host_port_pkg::ST_HALT) begin
      irq_nxt = 1'b1; // RULE12
    end
    // clear only when no event lands in the same cycle
    if (wr_clear && !(|events_in)) begin
      irq_nxt = 1'b0; // RULE3 RULE9
    end
    case (st_r)
      host_port_pkg::ST_HALT: begin
        // interrupt already handled above: a same-cycle event beats clear
        if (wr_clear) begin
          st_nxt = host_port_pkg::ST_IDLE; // RULE3
        end
      end
      host_port_pkg::ST_IDLE: begin
        if (wr_start && !linked_r) begin
          st_nxt = host_port_pkg::ST_WAKE; // RULE5 RULE16
          idx_nxt = 3'h0;
          maddr_nxt = wake_base;
          mreq_nxt = 1'b1;
        end else if (wr_start) begin
          st_nxt = host_port_pkg::ST_EXEC; // RULE6
          xs_nxt = 1'b1;
        end
      end
      host_port_pkg::ST_WAKE: begin
        mreq_nxt = 1'b1;
        if (mem_ack_in) begin
          // byte 0 extension, byte 1 reserved, bytes 2..5 address
          if (idx_r == 3'(host_port_pkg::WAKE_EXT_BYTE)) begin
            ext_nxt = mem_data_in; // RULE18
          end else if (idx_r >= 3'(host_port_pkg::WAKE_ADDR_BYTE)) begin
            ccb_nxt = {mem_data_in, ccb_r[31:8]}; // RULE18
          end
          idx_nxt = idx_r + 3'h1;
          maddr_nxt = maddr_r + 24'h1;
          if (idx_r == 3'(host_port_pkg::WAKE_BYTES - 1)) begin
            mreq_nxt = 1'b0;
            st_nxt = host_port_pkg::ST_CLRBUSY;
          end
        end
      end
      host_port_pkg::ST_CLRBUSY: begin
        // busy goes idle, no status is posted
        bw_nxt = 1'b1; // RULE5 RULE19
        bv_nxt = host_port_pkg::BUSY_IDLE;
        linked_nxt = 1'b1;
        st_nxt = host_port_pkg::ST_IDLE;
      end
      host_port_pkg::ST_EXEC: begin
        if (exec_done_in) begin
          post_nxt = semaphore_zero_in; // RULE20
          bw_nxt = 1'b1; // RULE19
          bv_nxt = host_port_pkg::BUSY_IDLE;
          st_nxt = host_port_pkg::ST_IDLE;
        end
      end
      default: st_nxt = host_port_pkg::ST_HALT;
    endcase
    // reset command wins over everything and drops all progress
    if (wr_reset || bus_init_in) begin
      st_nxt = host_port_pkg::ST_HALT; // RULE7
      linked_nxt = 1'b0;
      mreq_nxt = 1'b0;
      bw_nxt = 1'b0;
      post_nxt = 1'b0;
      xs_nxt = 1'b0;
      irq_nxt = bus_init_in ? 1'b0 : irq_nxt; // RULE9
    end
  end

  // registers, frozen while the clock enable is low unless the synchronous reset is asserted
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      st_r <= host_port_pkg::ST_HALT;
      idx_r <= 3'h0;
      ext_r <= host_port_pkg::EXT_NONE;
      ccb_r <= 32'h0;
      linked_r <= 1'b0;
      irq_r <= 1'b0;
      maddr_r <= 24'h0;
      mreq_r <= 1'b0;
      bw_r <= 1'b0;
      bv_r <= host_port_pkg::BUSY_SET;
      xs_r <= 1'b0;
      post_r <= 1'b0;
      xl_r <= 24'h0;
    end else if (ce_in) begin
      st_r <= st_nxt;
      idx_r <= idx_nxt;
      ext_r <= ext_nxt;
      ccb_r <= ccb_nxt;
      linked_r <= linked_nxt;
      irq_r <= irq_nxt;
      maddr_r <= maddr_nxt;
      mreq_r <= mreq_nxt;
      bw_r <= bw_nxt;
      bv_r <= bv_nxt;
      xs_r <= xs_nxt;
      post_r <= post_nxt;
      xl_r <= xl_nxt;
    end
  end

  // interrupt steered onto one jumpered line
  genvar g;
  generate
    for (g = 0; g < host_port_pkg::IRQ_LINES; g++) begin : g_irq
      assign irq_out[g] = irq_r &&
        (interrupt_line_jumper_in == 3'(g)); // RULE8
    end
  endgenerate

  assign mem_req_out = mreq_r;
  assign mem_addr_out = maddr_r;
  assign busy_write_out = bw_r;
  assign busy_value_out = bv_r;
  assign exec_start_out = xs_r;
  assign abort_out = wr_reset; // RULE7
  assign status_post_out = post_r;
  assign in_reset_out = (st_r == host_port_pkg::ST_HALT);
  assign linear_mode_out = lin;
  assign ext_sel_out = ext_r;
  assign chain_addr_out = xlate(lin, ccb_r[15:0], ccb_r[31:16]);
  assign xlate_addr_out = xl_r;

  // checks
  clear_drops_a: assert property (@(posedge clk_in) // RULE3
    disable iff (!resetn_in)
    ce_in && wr_clear && !(|events_in) && !wr_reset && !bus_init_in
    |=> !irq_r) else $error("clear left interrupt set");
  reset_halts_a: assert property (@(posedge clk_in) // RULE7
    disable iff (!resetn_in)
    ce_in && wr_reset |=> st_r == host_port_pkg::ST_HALT && !linked_r)
    else $error("reset did not halt");
  seek_sets_a: assert property (@(posedge clk_in) // RULE11
    disable iff (!resetn_in)
    ce_in && events_in.seek_done && !bus_init_in |=> irq_r)
    else $error("seek did not interrupt");
  mask_done_a: assert property (@(posedge clk_in) // RULE12
    disable iff (!resetn_in)
    ce_in && !irq_r && events_in == 3'b100
    && modifier_in[host_port_pkg::MOD_NO_INT_BIT] |=> !irq_r)
    else $error("masked completion interrupted");
  irq_hold_a: assert property (@(posedge clk_in) // RULE9
    disable iff (!resetn_in)
    irq_r && !wr_clear && !bus_init_in |=> irq_r)
    else $error("interrupt dropped");
  wake_addr_a: assert property (@(posedge clk_in) // RULE15
    disable iff (!resetn_in)
    ce_in && st_r == host_port_pkg::ST_IDLE && wr_start && !linked_r
    |=> mem_addr_out == {4'h0, $past(port_jumper_in), 4'h0})
    else $error("wrong wake-up address");
  later_start_a: assert property (@(posedge clk_in) // RULE6
    disable iff (!resetn_in)
    ce_in && st_r == host_port_pkg::ST_IDLE && wr_start && linked_r
    && !bus_init_in |=> exec_start_out && !mem_req_out)
    else $error("no exec");
  one_line_a: assert property (@(posedge clk_in) // RULE8
    disable iff (!resetn_in)
    $onehot0(irq_out)) else $error("several lines driven");
  ignore_three_a: assert property (@(posedge clk_in) // RULE21
    disable iff (!resetn_in)
    io_write_in && cmd == host_port_pkg::CMD_NONE && !(|events_in)
    && !bus_init_in && !exec_done_in && st_r != host_port_pkg::ST_WAKE
    && st_r != host_port_pkg::ST_CLRBUSY
    |=> $stable(st_r) && $stable(irq_r) && $stable(linked_r))
    else $error("03H changed state");
  // the end of the wake-up fetch writes idle busy and posts nothing
  clear_busy_a: assert property (@(posedge clk_in) // RULE5
    disable iff (!resetn_in)
    ce_in && st_r == host_port_pkg::ST_CLRBUSY && !wr_reset && !bus_init_in
    |=> busy_write_out && busy_value_out == host_port_pkg::BUSY_IDLE
    && !status_post_out) else $error("first start ended wrongly");
  // a low clock enable must hold the state, the interrupt and the wake-up flag
  freeze_all_a: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    !ce_in |=> $stable(st_r) && $stable(irq_r) && $stable(linked_r))
    else $error("state moved while disabled");
endmodule : host_command_port

// >>> hdl/host_port_pkg.sv
package host_port_pkg;
  // port command codes (two low bits of the written value)
  localparam logic [1:0] CMD_CLEAR = 2'h0;
  localparam logic [1:0] CMD_START = 2'h1;
  localparam logic [1:0] CMD_RESET = 2'h2;
  localparam logic [1:0] CMD_NONE = 2'h3;
  // wake-up block layout
  localparam int WAKE_BYTES = 6;
  localparam logic [7:0] EXT_NONE = 8'h01;
  localparam logic [7:0] EXT_ALL = 8'h07;
  localparam int WAKE_EXT_BYTE = 0;
  localparam int WAKE_ADDR_BYTE = 2;
  // busy byte values in the channel control block
  localparam logic [7:0] BUSY_SET = 8'hff;
  localparam logic [7:0] BUSY_IDLE = 8'h00;
  // modifier bit that suppresses the completion interrupt
  localparam int MOD_NO_INT_BIT = 0;
  // address arithmetic and interrupt line count
  localparam int SEG_SHIFT = 4;
  localparam int SEG_ADDR_W = 20;
  localparam int LIN_ADDR_W = 24;
  localparam int IRQ_LINES = 8;
  // interrupt cause bundle
  typedef struct packed {
    logic cmd_done;
    logic seek_done;
    logic media_change;
  } irq_events_t;
  // engine states
  typedef enum logic [2:0] {
    ST_HALT = 3'b000,
    ST_IDLE = 3'b001,
    ST_WAKE = 3'b010,
    ST_CLRBUSY = 3'b011,
    ST_EXEC = 3'b100
  } state_t;
endpackage : host_port_pkg

// >>> testbench/host_mem_model.sv
`timescale 1ns/1ps
// host memory: hands out the wake-up block one byte per request
module host_mem_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // byte fetch port
  input wire logic mem_req_in,
  input wire logic [23:0] mem_addr_in,
  output logic mem_ack_out,
  output logic [7:0] mem_data_out,
  // block image, its base and the answer delay
  input wire logic [47:0] wake_in,
  input wire logic [23:0] base_in,
  input wire logic [3:0] stall_in
);
  logic [3:0] wait_r; // cycles left before answering
  logic [7:0] last_r = 8'h00; // last byte handed out
  logic [23:0] off; // byte index inside the block
  assign off = mem_addr_in - base_in;
  initial mem_ack_out = 1'b0;
  initial mem_data_out = 8'h00;
  // after each answer one idle cycle lets the new address settle;
  // released data shows the inverse so a late sample never matches
  always @(posedge clk_in) begin
    mem_ack_out <= 1'b0;
    mem_data_out <= ~last_r;
    if (!resetn_in || !mem_req_in) begin
      wait_r <= stall_in;
    end else if (!mem_ack_out) begin
      if (wait_r != 4'h0) begin
        wait_r <= wait_r - 4'h1;
      end else begin
        // extension, reserved, then address bytes low first
        mem_ack_out <= 1'b1;
        mem_data_out <= (off < 6) ? wake_in[8*off +: 8] : ~last_r;
        last_r <= (off < 6) ? wake_in[8*off +: 8] : ~last_r;
        wait_r <= stall_in;
      end
    end
  end
endmodule : host_mem_model

// >>> testbench/host_command_port_and_wakeup_chain_bench.sv
`timescale 1ns/1ps
// drives the host port; pulses are checked against queued notes
module host_command_port_and_wakeup_chain_bench;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic bus_init_in = 1'b0;
  logic [15:0] io_addr_in = 16'h0000;
  logic io_write_in = 1'b0;
  logic io_read_in = 1'b0;
  logic [7:0] io_data_in = 8'h00;
  logic [15:0] jmp = 16'h0000;
  logic [2:0] line = 3'h0;
  host_port_pkg::irq_events_t events_in = '0;
  logic [15:0] modifier_in = 16'h0000;
  logic sem_zero = 1'b1;
  logic exec_done_in = 1'b0;
  logic [15:0] seg_in = 16'h0000;
  logic [15:0] off_in = 16'h0000;
  logic [47:0] wake = 48'h0;
  logic [3:0] stall = 4'h0;
  logic ce = 1'b1; // clock enable of the design
  logic wide = 1'b1; // full 16-bit port compare
  logic [31:0] exp_v; // expected value of the current check
  logic mem_req, mem_ack, busy_wr, exec_st, abort, post, in_reset, linear;
  logic abort_seen;
  logic [7:0] mem_data, busy_val, ext_sel, irq;
  logic [23:0] mem_addr, chain, xlate;
  logic [15:0] lfsr_r = 16'h0032;
  logic [15:0] exp_q[$]; // notes: kind byte, value byte
  int failures = 0;
  int compares = 0;
  always #10 clk_in = ~clk_in;
  host_command_port u_host_command_port (.clk_in, .resetn_in, .ce_in(ce),
    .bus_init_in, .io_addr_in, .io_write_in, .io_read_in, .io_data_in,
    .wide_port_in(wide), .port_jumper_in(jmp),
    .interrupt_line_jumper_in(line), .mem_req_out(mem_req),
    .mem_addr_out(mem_addr), .mem_ack_in(mem_ack), .mem_data_in(mem_data),
    .events_in, .modifier_in, .semaphore_zero_in(sem_zero), .exec_done_in,
    .seg_in, .off_in, .busy_write_out(busy_wr), .busy_value_out(busy_val),
    .exec_start_out(exec_st), .abort_out(abort), .status_post_out(post),
    .in_reset_out(in_reset), .linear_mode_out(linear),
    .ext_sel_out(ext_sel), .chain_addr_out(chain), .xlate_addr_out(xlate),
    .irq_out(irq));
  host_mem_model u_host_mem_model (.clk_in, .resetn_in, .mem_req_in(mem_req),
    .mem_addr_in(mem_addr), .mem_ack_out(mem_ack), .mem_data_out(mem_data),
    .wake_in(wake), .base_in({4'h0, jmp, 4'h0}), .stall_in(stall));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    compares++;
    if (got !== want) begin
      failures++;
      $display("MISMATCH t=%0t got %h want %h", $time, got, want);
    end
  endtask : cmp
  task automatic report_and_stop();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // oldest note, or a value no note holds when none is waiting
  function automatic logic [15:0] pop_note();
    return (exp_q.size() != 0) ? exp_q.pop_front() : 16'hdead;
  endfunction : pop_note
  // watcher: busy write before status post before exec start
  always @(negedge clk_in) begin
    if (busy_wr === 1'b1) cmp({8'h01, busy_val}, pop_note());
    if (post === 1'b1) cmp(16'h0300, pop_note());
    if (exec_st === 1'b1) cmp(16'h0200, pop_note());
  end
  // one port cycle, entered and left at a falling edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic rd);
    io_addr_in = a;
    io_data_in = d;
    io_write_in = !rd;
    io_read_in = rd;
    @(posedge clk_in) abort_seen = abort;
    @(negedge clk_in);
    io_write_in = 1'b0;
    io_read_in = 1'b0;
    @(negedge clk_in);
  endtask : wr
  // bounded wait until every note was met; a stuck note ends the run
  task automatic drain();
    for (int n = 0; n < 300 && exp_q.size() != 0; n++) @(negedge clk_in);
    cmp(exp_q.size(), 0);
    if (exp_q.size() != 0) report_and_stop();
  endtask : drain
  task automatic wake_up(input logic [7:0] ext, input logic [3:0] st);
    logic [15:0] w0, w1;
    w0 = lfsr_r;
    w1 = lfsr(w0);
    lfsr_r = lfsr(w1);
    wake = {w1, w0, 8'h00, ext};
    stall = st;
    wr(jmp, 8'h00, 1'b0);
    cmp(in_reset, 0);
    exp_q.push_back(16'h0100);
    wr(jmp, 8'h01, 1'b0);
    cmp({mem_req, mem_addr}, {1'b1, 4'h0, jmp, 4'h0});
    wr(jmp, 8'h01, 1'b0); // second start while fetching must be refused
    drain();
    cmp({linear, ext_sel}, {ext == 8'h07, ext});
    exp_v = ext == host_port_pkg::EXT_ALL ? {w1[7:0], w0}
      : 20'({w1, 4'h0} + w0);
    cmp(chain, exp_v);
    for (int i = 0; i < 4; i++) begin
      lfsr_r = lfsr(lfsr_r);
      seg_in = lfsr_r;
      off_in = ~lfsr_r;
      @(negedge clk_in);
      exp_v = ext == host_port_pkg::EXT_ALL ? {seg_in[7:0], off_in}
        : 20'({seg_in, 4'h0} + off_in);
      cmp(xlate, exp_v);
    end
    $display("test wake-up ext %h done", ext);
  endtask : wake_up
  initial begin
    lfsr_r = lfsr(lfsr_r);
    jmp = lfsr_r;
    repeat (12) @(negedge clk_in);
    resetn_in = 1'b1;
    cmp({in_reset, irq}, 9'h100);
    wr(jmp, 8'h01, 1'b0);
    cmp(mem_req, 0);
    wr(jmp, 8'h00, 1'b1);
    wr(jmp ^ 16'h0100, 8'h00, 1'b0);
    cmp(in_reset, 1);
    // a clear while the clock enable is low must not be taken
    ce = 1'b0;
    wr(jmp, 8'h00, 1'b0);
    cmp(in_reset, 1);
    ce = 1'b1;
    // narrow port: only the low address byte is compared
    wide = 1'b0;
    wr(jmp ^ 16'h0100, 8'h00, 1'b0);
    cmp(in_reset, 0);
    wr(jmp ^ 16'h0001, 8'h02, 1'b0);
    cmp(in_reset, 0);
    wr(jmp ^ 16'h0100, 8'h02, 1'b0);
    cmp(in_reset, 1);
    wide = 1'b1;
    $display("test decode done");
    // reset in the middle of a wake-up fetch stops it at once
    stall = 4'h4;
    wr(jmp, 8'h00, 1'b0);
    wr(jmp, 8'h01, 1'b0);
    wr(jmp, 8'h02, 1'b0);
    cmp({abort_seen, in_reset, mem_req}, 3'b110);
    $display("test abort done");
    wake_up(host_port_pkg::EXT_NONE, 4'h3);
    for (int k = 0; k < 2; k++) begin
      sem_zero = k[0];
      exp_q.push_back(16'h0200);
      wr(jmp, 8'h01, 1'b0);
      exp_q.push_back(16'h0100);
      if (sem_zero) exp_q.push_back(16'h0300);
      exec_done_in = 1'b1;
      @(negedge clk_in);
      exec_done_in = 1'b0;
      drain();
    end
    $display("test execute done");
    // every cause on a fresh line, completion masked on the first pass
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 3; i++) begin
        lfsr_r = lfsr(lfsr_r);
        line = lfsr_r[2:0];
        modifier_in = 16'(m == 0);
        events_in = 3'(1 << i);
        @(negedge clk_in);
        events_in = '0;
        wr(jmp, 8'h03, 1'b0);
        exp_v = (m == 0 && i == 2) ? 8'h00 : 8'h01 << line;
        cmp(irq, exp_v);
        wr(jmp, 8'h00, 1'b0);
        cmp(irq, 0);
      end
    end
    $display("test interrupt done");
    events_in.seek_done = 1'b1;
    @(negedge clk_in);
    events_in = '0;
    wr(jmp, 8'h02, 1'b0);
    cmp({in_reset, irq}, {1'b1, 8'h01 << line});
    bus_init_in = 1'b1;
    @(negedge clk_in);
    bus_init_in = 1'b0;
    @(negedge clk_in);
    cmp(irq, 0);
    $display("test bus init done");
    wake_up(host_port_pkg::EXT_ALL, 4'h0);
    report_and_stop();
  end
endmodule : host_command_port_and_wakeup_chain_bench
